// [src/srwl_pkg.sv]
// Function
// - Direct opcode shifted MSB first picks register
// - Data bytes arrive MSB first, assembled in order
// - Direct write end clears write enable latch
// - Release off byte boundary aborts, nothing changes
// - Register one opcode with two bytes fills two
// - Indirect: opcode, address, one data byte
// - Addresses one to five map registers one-five
// - Extra indirect data byte leaves registers unchanged
// - Bad indirect address writes nothing, clears latch
// - Indirect write needs write enable latch set
// - Volatile enable arms next direct write, latch untouched
// - Lock accepted only with latch set
// - Lock needs both verification bytes in order
// - Protect bits alone never lock registers
// - Once locked, register programming is refused
package srwl_pkg;
	// Command opcodes
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_VOL_ENABLE = 8'h50;
	localparam logic [7:0] OP_DIRECT_ONE = 8'h01;
	localparam logic [7:0] OP_DIRECT_TWO = 8'h31;
	localparam logic [7:0] OP_DIRECT_THREE = 8'h11;
	localparam logic [7:0] OP_INDIRECT = 8'h71;
	localparam logic [7:0] OP_LOCK = 8'h6f;
	localparam logic [7:0] LOCK_KEY_FIRST = 8'h4d;
	localparam logic [7:0] LOCK_KEY_SECOND = 8'h67;
	// Register offsets
	localparam logic [7:0] ADDR_ONE = 8'h01;
	localparam logic [7:0] ADDR_TWO = 8'h02;
	localparam logic [7:0] ADDR_THREE = 8'h03;
	localparam logic [7:0] ADDR_FOUR = 8'h04;
	localparam logic [7:0] ADDR_FIVE = 8'h05;
	// Reset values
	localparam logic [7:0] CFG_ONE_RST = 8'h00;
	localparam logic [7:0] CFG_TWO_RST = 8'h00;
	localparam logic [7:0] CFG_THREE_RST = 8'h00;
	localparam logic [7:0] CFG_FOUR_RST = 8'h00;
	localparam logic [7:0] CFG_FIVE_RST = 8'h00;
	localparam logic SYS_SEQ_RST = 1'h1;
	localparam logic LINK_SEQ_RST = 1'h0;
	localparam logic CS_IDLE = 1'h1;
	// Field positions
	localparam logic [2:0] WEL_POS = 3'h1;
	localparam logic [2:0] PROT_LOW_POS = 3'h7;
	localparam logic [2:0] PROT_HIGH_POS = 3'h0;
	// Frame lengths in bytes, opcode included; stored-byte count, count saturation and last bit index
	localparam logic [2:0] NB_ENABLE = 3'h1;
	localparam logic [2:0] NB_DIRECT_MIN = 3'h2;
	localparam logic [2:0] NB_DIRECT_PAIR = 3'h3;
	localparam logic [2:0] NB_INDIRECT = 3'h3;
	localparam logic [2:0] NB_LOCK = 3'h3;
	localparam logic [2:0] NB_STORED = 3'h3;
	localparam logic [2:0] NB_SAT = 3'h7;
	localparam logic [2:0] BIT_LAST = 3'h7;

	typedef enum logic [5:0] {
		CMD_OTHER = 6'h01,
		CMD_WREN = 6'h02,
		CMD_VOLEN = 6'h04,
		CMD_DIRECT = 6'h08,
		CMD_INDIRECT = 6'h10,
		CMD_LOCK = 6'h20
	} srwl_cmd_t;

	// One-hot register select; zero for unmapped addresses
	function automatic logic [4:0] srwl_reg_hot(input logic [7:0] addr);
		logic [4:0] hot;
		hot = 5'h00;
		case (addr)
			ADDR_ONE: hot = 5'h01;
			ADDR_TWO: hot = 5'h02;
			ADDR_THREE: hot = 5'h04;
			ADDR_FOUR: hot = 5'h08;
			ADDR_FIVE: hot = 5'h10;
			default: hot = 5'h00;
		endcase
		return hot;
	endfunction : srwl_reg_hot
endpackage : srwl_pkg

// [src/srwl_link_rx.sv]
`timescale 1ns/1ps
`default_nettype none
module srwl_link_rx
	import srwl_pkg::*;
(
	input wire logic spiClk,
	input wire logic reset,
	input wire logic spiDataIn,
	input wire logic frameSeq,
	output logic seqSeen,
	output logic [2:0] bitCount,
	output logic [2:0] byteCount,
	output logic [7:0] byteZero,
	output logic [7:0] byteOne,
	output logic [7:0] byteTwo
);
	typedef struct packed {
		logic seq;
		logic [2:0] bits;
		logic [2:0] bytes;
		logic [7:0] shift;
		logic [2:0][7:0] data;
	} srwl_link_t;

	srwl_link_t q;
	srwl_link_t d;
	logic fresh;
	logic [2:0] bitsNow;
	logic [2:0] bytesNow;
	logic [7:0] shiftNext;

	// A sequence mismatch marks the first edge of a new frame
	always_comb begin
		d = q;
		fresh = (q.seq != frameSeq);
		bitsNow = fresh ? 3'h0 : q.bits;
		bytesNow = fresh ? 3'h0 : q.bytes;
		shiftNext = {(fresh ? 7'h00 : q.shift[6:0]), spiDataIn};
		d.seq = frameSeq;
		d.shift = shiftNext;
		d.bits = bitsNow + 3'h1;
		d.bytes = bytesNow;
		if (bitsNow == BIT_LAST) begin
			// Only three bytes kept; the count saturates for length checks
			if (bytesNow < NB_STORED)
				d.data[bytesNow[1:0]] = shiftNext;
			if (bytesNow != NB_SAT)
				d.bytes = bytesNow + 3'h1;
		end
	end

	// Clock stops outside frames, so reset must act without it
	always_ff @(posedge spiClk or posedge reset) begin
		if (reset) begin
			q <= '0;
			q.seq <= LINK_SEQ_RST;
		end else begin
			q <= d;
		end
	end

	assign seqSeen = q.seq;
	assign bitCount = q.bits;
	assign byteCount = q.bytes;
	assign byteZero = q.data[0];
	assign byteOne = q.data[1];
	assign byteTwo = q.data[2];

	opcode_msb_a: assert property (
		@(posedge spiClk) disable iff (reset)
		(fresh ##1 (!fresh) [*7]) |=> q.data[0] == {$past(spiDataIn, 8),
		$past(spiDataIn, 7), $past(spiDataIn, 6), $past(spiDataIn, 5),
		$past(spiDataIn, 4), $past(spiDataIn, 3), $past(spiDataIn, 2),
		$past(spiDataIn, 1)})
		else $error("opcode not assembled msb first");

	byte_count_a: assert property (
		@(posedge spiClk) disable iff (reset)
		(!fresh && q.bits == BIT_LAST && q.bytes < NB_STORED)
		|=> q.bytes == $past(q.bytes) + 3'h1 && q.bits == 3'h0)
		else $error("byte count did not advance");
endmodule : srwl_link_rx
`default_nettype wire

// [src/srwl_core.sv]
`timescale 1ns/1ps
`default_nettype none
module srwl_core
	import srwl_pkg::*;
(
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic spiClk,
	input wire logic spiCsN,
	input wire logic spiDataIn,
	output logic [7:0] statusOne,
	output logic [7:0] statusTwo,
	output logic [7:0] statusThree,
	output logic [7:0] statusFour,
	output logic [7:0] statusFive,
	output logic writeEnableLatch,
	output logic volatileArmed,
	output logic regsLocked
);
	typedef struct packed {
		logic csMeta;
		logic csSync;
		logic csLast;
		logic seq;
		logic volArm;
		logic locked;
		logic [4:0][7:0] cfg;
	} srwl_sys_t;

	srwl_sys_t q;
	srwl_sys_t d;
	srwl_cmd_t kind;
	logic linkSeq;
	logic [2:0] linkBits;
	logic [2:0] linkBytes;
	logic [7:0] byteZero;
	logic [7:0] byteOne;
	logic [7:0] byteTwo;
	logic frameEnd;
	logic live;
	logic aligned;
	logic write_enable_latch;
	logic protSet;
	logic keysOk;
	logic [7:0] directAddr;
	logic [4:0] hot;
	logic [7:0] wrData;

	// Link side: shifts bytes on the serial clock
	srwl_link_rx u_link (
		.spiClk(spiClk),
		.reset(reset),
		.spiDataIn(spiDataIn),
		.frameSeq(q.seq),
		.seqSeen(linkSeq),
		.bitCount(linkBits),
		.byteCount(linkBytes),
		.byteZero(byteZero),
		.byteOne(byteOne),
		.byteTwo(byteTwo)
	);

	// Frame end is the synchronised rise of chip select; link words
	// are read only then, when the serial clock has stopped
	assign frameEnd = q.csSync & ~q.csLast;
	assign live = (linkSeq == q.seq);
	assign aligned = (linkBits == 3'h0);
	assign write_enable_latch = q.cfg[0][WEL_POS];
	assign protSet = q.cfg[0][PROT_LOW_POS] & q.cfg[1][PROT_HIGH_POS];
	assign keysOk = (byteOne == LOCK_KEY_FIRST)
		&& (byteTwo == LOCK_KEY_SECOND);

	// Opcode decode and direct register selection
	always_comb begin
		kind = CMD_OTHER;
		directAddr = 8'h00;
		case (byteZero)
			OP_WRITE_ENABLE: kind = CMD_WREN;
			OP_VOL_ENABLE: kind = CMD_VOLEN;
			OP_DIRECT_ONE: begin
				kind = CMD_DIRECT;
				directAddr = ADDR_ONE;
			end
			OP_DIRECT_TWO: begin
				kind = CMD_DIRECT;
				directAddr = ADDR_TWO;
			end
			OP_DIRECT_THREE: begin
				kind = CMD_DIRECT;
				directAddr = ADDR_THREE;
			end
			OP_INDIRECT: kind = CMD_INDIRECT;
			OP_LOCK: kind = CMD_LOCK;
			default: kind = CMD_OTHER;
		endcase
	end

	// Command execution, all at the end of the frame
	always_comb begin
		d = q;
		hot = 5'h00;
		wrData = 8'h00;
		d.csMeta = spiCsN;
		d.csSync = q.csMeta;
		d.csLast = q.csSync;
		if (frameEnd) begin
			d.seq = ~q.seq;
			// Partial byte or no clock at all: drop the frame
			if (live && aligned) begin
				unique case (kind)
					CMD_WREN: begin
						if (linkBytes == NB_ENABLE)
							d.cfg[0][WEL_POS] = 1'b1;
					end
					CMD_VOLEN: begin
						// Latch left alone; arms one write only
						if (linkBytes == NB_ENABLE)
							d.volArm = 1'b1;
					end
					CMD_DIRECT: begin
						// Locked: no write and the latch is kept
						if (linkBytes >= NB_DIRECT_MIN && !q.locked) begin
							d.volArm = 1'b0;
							if (write_enable_latch || q.volArm) begin
								hot = srwl_reg_hot(directAddr);
								wrData = byteOne;
							end
							d.cfg[0][WEL_POS] = 1'b0;
						end
					end
					CMD_INDIRECT: begin
						// Extra data bytes fail the length test
						if (linkBytes == NB_INDIRECT && write_enable_latch
							&& !q.locked) begin
							hot = srwl_reg_hot(byteOne);
							wrData = byteTwo;
							d.volArm = 1'b0;
							d.cfg[0][WEL_POS] = 1'b0;
						end
					end
					CMD_LOCK: begin
						if (linkBytes == NB_LOCK && write_enable_latch && keysOk) begin
							d.locked = q.locked | protSet;
							d.cfg[0][WEL_POS] = 1'b0;
						end
					end
					CMD_OTHER: begin
					end
				endcase
				for (int i = 0; i < 5; i++) begin
					if (hot[i])
						d.cfg[i] = wrData;
				end
				// Legacy pair form also loads register two
				if (hot[0] && kind == CMD_DIRECT
					&& linkBytes >= NB_DIRECT_PAIR)
					d.cfg[1] = byteTwo;
				// Latch bit belongs to hardware, not to write data
				if (hot[0])
					d.cfg[0][WEL_POS] = 1'b0;
			end
		end
	end

	// Chip select idles high so no frame end appears at reset
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			q <= '0;
			q.csMeta <= CS_IDLE;
			q.csSync <= CS_IDLE;
			q.csLast <= CS_IDLE;
			q.seq <= SYS_SEQ_RST;
			q.cfg[0] <= CFG_ONE_RST;
			q.cfg[1] <= CFG_TWO_RST;
			q.cfg[2] <= CFG_THREE_RST;
			q.cfg[3] <= CFG_FOUR_RST;
			q.cfg[4] <= CFG_FIVE_RST;
		end else begin
			q <= d;
		end
	end

	assign statusOne = q.cfg[0];
	assign statusTwo = q.cfg[1];
	assign statusThree = q.cfg[2];
	assign statusFour = q.cfg[3];
	assign statusFive = q.cfg[4];
	assign writeEnableLatch = q.cfg[0][WEL_POS];
	assign volatileArmed = q.volArm;
	assign regsLocked = q.locked;

	direct_clear_a: assert property (
		@(posedge clk_sys) disable iff (reset)
		(frameEnd && live && aligned && kind == CMD_DIRECT
			&& linkBytes >= NB_DIRECT_MIN && !q.locked)
		|=> !writeEnableLatch)
		else $error("latch not cleared after direct write");

	partial_abort_a: assert property (
		@(posedge clk_sys) disable iff (reset)
		(frameEnd && !aligned)
		|=> $stable(q.cfg) && $stable(q.locked) && $stable(q.volArm))
		else $error("partial byte frame changed state");

	pair_write_a: assert property (
		@(posedge clk_sys) disable iff (reset)
		(frameEnd && live && aligned && byteZero == OP_DIRECT_ONE
			&& linkBytes == NB_DIRECT_PAIR && !q.locked && write_enable_latch)
		|=> statusTwo == $past(byteTwo)
			&& statusOne[PROT_LOW_POS] == $past(byteOne[PROT_LOW_POS]))
		else $error("pair write did not fill two registers");

	addr_map_a: assert property (
		@(posedge clk_sys) disable iff (reset)
		(frameEnd && live && aligned && kind == CMD_INDIRECT && write_enable_latch
			&& linkBytes == NB_INDIRECT && !q.locked
			&& byteOne == ADDR_FIVE)
		|=> statusFive == $past(byteTwo) && $stable(statusFour))
		else $error("indirect address five misrouted");

	extra_byte_a: assert property (
		@(posedge clk_sys) disable iff (reset)
		(frameEnd && kind == CMD_INDIRECT && linkBytes > NB_INDIRECT)
		|=> $stable(q.cfg))
		else $error("over-long indirect write changed registers");

	bad_addr_a: assert property (
		@(posedge clk_sys) disable iff (reset)
		(frameEnd && live && aligned && kind == CMD_INDIRECT
			&& linkBytes == NB_INDIRECT && !q.locked
			&& (byteOne == 8'h00 || byteOne > ADDR_FIVE))
		|=> !writeEnableLatch && $stable(statusTwo)
			&& $stable(statusThree) && $stable(statusFive))
		else $error("bad indirect address not aborted");

	need_latch_a: assert property (
		@(posedge clk_sys) disable iff (reset)
		(frameEnd && kind == CMD_INDIRECT && !write_enable_latch) |=> $stable(q.cfg))
		else $error("indirect write ran without latch");

	vol_arm_a: assert property (
		@(posedge clk_sys) disable iff (reset)
		(frameEnd && live && aligned && kind == CMD_VOLEN
			&& linkBytes == NB_ENABLE)
		|=> volatileArmed && $stable(writeEnableLatch))
		else $error("volatile enable misbehaved");

	lock_cause_a: assert property (
		@(posedge clk_sys) disable iff (reset)
		$rose(regsLocked)
		|-> $past(frameEnd) && $past(kind) == CMD_LOCK && $past(keysOk)
			&& $past(write_enable_latch) && $past(protSet))
		else $error("lock set without full sequence");

	bad_key_a: assert property (
		@(posedge clk_sys) disable iff (reset)
		(frameEnd && kind == CMD_LOCK && !keysOk)
		|=> $stable(regsLocked) && $stable(writeEnableLatch))
		else $error("lock taken with wrong verification bytes");

	locked_hold_a: assert property (
		@(posedge clk_sys) disable iff (reset)
		(regsLocked && frameEnd
			&& (kind == CMD_DIRECT || kind == CMD_INDIRECT))
		|=> $stable(q.cfg) ##1 regsLocked)
		else $error("write accepted while locked");

	wren_set_a: assert property (
		@(posedge clk_sys) disable iff (reset)
		(frameEnd && live && aligned && kind == CMD_WREN
			&& linkBytes == NB_ENABLE)
		|=> writeEnableLatch)
		else $error("write enable did not set latch");

	lock_latch_a: assert property (
		@(posedge clk_sys) disable iff (reset)
		(frameEnd && kind == CMD_LOCK && !write_enable_latch)
		|=> $stable(regsLocked))
		else $error("lock taken without latch");

	lock_done_a: assert property (
		@(posedge clk_sys) disable iff (reset)
		(frameEnd && live && aligned && kind == CMD_LOCK
			&& linkBytes == NB_LOCK && write_enable_latch && keysOk)
		|=> !writeEnableLatch)
		else $error("latch kept after lock command");

	arm_used_a: assert property (
		@(posedge clk_sys) disable iff (reset)
		(frameEnd && live && aligned && kind == CMD_DIRECT
			&& linkBytes >= NB_DIRECT_MIN && !q.locked)
		|=> !volatileArmed)
		else $error("volatile arm not consumed");

	locked_latch_a: assert property (
		@(posedge clk_sys) disable iff (reset)
		(regsLocked && frameEnd && live && aligned
			&& (kind == CMD_DIRECT || kind == CMD_INDIRECT))
		|=> $stable(writeEnableLatch))
		else $error("locked write touched latch");

	single_byte_a: assert property (
		@(posedge clk_sys) disable iff (reset)
		(frameEnd && live && aligned && byteZero == OP_DIRECT_ONE
			&& linkBytes == NB_DIRECT_MIN)
		|=> $stable(statusTwo))
		else $error("single byte write changed register two");
endmodule : srwl_core
`default_nettype wire

// [tb/srwl_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module srwl_host_model (
	input wire logic clk_sys,
	output logic spiClk,
	output logic spiCsN,
	output logic spiDataIn
);
	// Link idles with clock low and select high
	initial begin
		spiClk = 1'h0;
		spiCsN = 1'h1;
		spiDataIn = 1'h0;
	end

	// One bit; data moves only while the clock is low
	task automatic shift_bit(input logic b);
		spiDataIn = b;
		#6 spiClk = 1'h1;
		#6 spiClk = 1'h0;
	endtask : shift_bit

	// Whole frame; extra bits end it off a byte boundary on purpose
	task automatic send(input logic [7:0] bytes[$], input int extra);
		@(posedge clk_sys);
		spiCsN <= 1'h0;
		#10;
		foreach (bytes[i]) begin
			for (int k = 7; k >= 0; k--) begin
				shift_bit(bytes[i][k]);
			end
		end
		for (int k = 0; k < extra; k++) begin
			shift_bit(k[0]);
		end
		#6;
		@(posedge clk_sys);
		spiCsN <= 1'h1;
		// Released line does not keep the last bit
		spiDataIn <= ~spiDataIn;
		// Gap covers the answer delay and the minimum idle time
		repeat (8) @(posedge clk_sys);
	endtask : send
endmodule : srwl_host_model
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import srwl_pkg::*;
	localparam logic [7:0] BAD_ADDR [3] = '{8'h00, 8'h06, 8'hff};
	logic clk_sys;
	logic reset;
	logic spiClk;
	logic spiCsN;
	logic spiDataIn;
	logic [7:0] statusOne, statusTwo, statusThree, statusFour, statusFive;
	logic writeEnableLatch, volatileArmed, regsLocked;
	logic [7:0] expReg [1:5];
	logic expWel, expArm, expLock;
	int n_fail = 0;
	int samples_checked = 0;

	srwl_core u_dut (.clk_sys(clk_sys), .reset(reset), .spiClk(spiClk),
		.spiCsN(spiCsN), .spiDataIn(spiDataIn), .statusOne(statusOne),
		.statusTwo(statusTwo), .statusThree(statusThree),
		.statusFour(statusFour), .statusFive(statusFive),
		.writeEnableLatch(writeEnableLatch), .volatileArmed(volatileArmed),
		.regsLocked(regsLocked));

	srwl_host_model u_host (.clk_sys(clk_sys), .spiClk(spiClk),
		.spiCsN(spiCsN), .spiDataIn(spiDataIn));

	// System clock, 50 ns period
	initial begin
		clk_sys = 1'h0;
		forever #25 clk_sys = ~clk_sys;
	end

	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		samples_checked++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Latch bit of register one follows the expected latch
	task automatic check_all(input string test);
		chk("statusOne", expReg[1] | {6'h00, expWel, 1'h0}, statusOne);
		chk("statusTwo", expReg[2], statusTwo);
		chk("statusThree", expReg[3], statusThree);
		chk("statusFour", expReg[4], statusFour);
		chk("statusFive", expReg[5], statusFive);
		chk("writeEnableLatch", {7'h00, expWel}, {7'h00, writeEnableLatch});
		chk("volatileArmed", {7'h00, expArm}, {7'h00, volatileArmed});
		chk("regsLocked", {7'h00, expLock}, {7'h00, regsLocked});
		$display("Test %s done", test);
	endtask : check_all

	task automatic wren();
		u_host.send({OP_WRITE_ENABLE}, 0);
		expWel = 1'h1;
	endtask : wren

	task automatic complete_run();
		$display("Comparisons %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : complete_run

	// Hang guard, well past the expected run of about 30 us
	initial begin
		#400000;
		n_fail++;
		complete_run();
	end

	// Main sequence
	initial begin
		reset = 1'h1;
		foreach (expReg[i]) expReg[i] = 8'h00;
		expWel = 1'h0;
		expArm = 1'h0;
		expLock = 1'h0;
		repeat (16) @(posedge clk_sys);
		reset <= 1'h0;
		@(posedge clk_sys);
		check_all("reset");
		u_host.send({OP_DIRECT_ONE, 8'h3c}, 0);
		check_all("no latch");
		wren();
		check_all("enable");
		// Data bit one is set but the latch must still drop
		u_host.send({OP_DIRECT_ONE, 8'h3e}, 0);
		expReg[1] = 8'h3c;
		expWel = 1'h0;
		check_all("direct one");
		wren();
		u_host.send({OP_DIRECT_THREE, 8'hc3}, 0);
		expReg[3] = 8'hc3;
		expWel = 1'h0;
		check_all("direct three");
		wren();
		u_host.send({OP_DIRECT_ONE, 8'h44, 8'h81}, 0);
		expReg[1] = 8'h44;
		expReg[2] = 8'h81;
		expWel = 1'h0;
		check_all("pair");
		u_host.send({OP_VOL_ENABLE}, 0);
		expArm = 1'h1;
		check_all("vol arm");
		u_host.send({OP_DIRECT_TWO, 8'h5a}, 0);
		expReg[2] = 8'h5a;
		expArm = 1'h0;
		check_all("vol write");
		for (int a = 1; a <= 5; a++) begin
			wren();
			u_host.send({OP_INDIRECT, 8'(a), 8'h50 + 8'(a)}, 0);
			expReg[a] = 8'h50 + 8'(a);
			expWel = 1'h0;
			check_all("indirect");
		end
		u_host.send({OP_INDIRECT, ADDR_THREE, 8'h77}, 0);
		check_all("indirect no latch");
		foreach (BAD_ADDR[i]) begin
			wren();
			u_host.send({OP_INDIRECT, BAD_ADDR[i], 8'h99}, 0);
			expWel = 1'h0;
			check_all("bad address");
		end
		wren();
		u_host.send({OP_INDIRECT, ADDR_TWO, 8'h11, 8'h22}, 0);
		check_all("extra byte");
		u_host.send({OP_DIRECT_ONE, 8'h00}, 5);
		check_all("partial byte");
		u_host.send({OP_DIRECT_ONE}, 0);
		check_all("no data");
		// Both protect bits set, still unlocked
		u_host.send({OP_DIRECT_ONE, 8'h80}, 0);
		expReg[1] = 8'h80;
		wren();
		u_host.send({OP_DIRECT_TWO, 8'h01}, 0);
		expReg[2] = 8'h01;
		expWel = 1'h0;
		check_all("protect bits");
		u_host.send({OP_LOCK, LOCK_KEY_FIRST, LOCK_KEY_SECOND}, 0);
		check_all("lock no latch");
		wren();
		u_host.send({OP_LOCK, LOCK_KEY_SECOND, LOCK_KEY_FIRST}, 0);
		chk("regsLocked", 8'h00, {7'h00, regsLocked});
		wren();
		u_host.send({OP_LOCK, LOCK_KEY_FIRST, LOCK_KEY_SECOND}, 0);
		expWel = 1'h0;
		expLock = 1'h1;
		check_all("lock");
		// Locked writes leave the latch standing
		wren();
		u_host.send({OP_DIRECT_ONE, 8'h00}, 0);
		u_host.send({OP_INDIRECT, ADDR_FIVE, 8'h00}, 0);
		check_all("locked");
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
